// ==== hdl/adc_ctrl_pkg.sv ====
// constants, offsets and types for the converter control block
package adc_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_RES = 8'h08;
  localparam logic [7:0] OFF_CMPV = 8'h0C;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_APC = 8'h14;
  localparam logic [7:0] OFF_PER = 8'h18;
  localparam logic [7:0] OFF_IST = 8'h1C;
  localparam logic [7:0] OFF_IMSK = 8'h20;

  // field positions
  localparam int SC1_DONE_BIT = 7;
  localparam int SC1_IEN_BIT = 6;
  localparam int SC1_CONT_BIT = 5;
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_HWT_BIT = 6;
  localparam int SC2_CMPEN_BIT = 5;
  localparam int SC2_CMPGE_BIT = 4;
  localparam int CFG_MODE8_BIT = 2;
  localparam int PER_SRC_BIT = 3;
  localparam int IST_DONE_BIT = 0;
  localparam int IST_CMP_BIT = 1;

  // selector codes
  localparam logic [4:0] CH_PIN_LAST = 5'h07;
  localparam logic [4:0] CH_GND_LAST = 5'h15;
  localparam logic [4:0] CH_TEMP = 5'h1A;
  localparam logic [4:0] CH_BGAP = 5'h1B;
  localparam logic [4:0] CH_REFH = 5'h1D;
  localparam logic [4:0] CH_REFL = 5'h1E;
  localparam logic [4:0] CH_OFF = 5'h1F;

  // reset values
  localparam logic [4:0] CH_RST = CH_OFF;
  localparam logic [1:0] CLKSEL_RST = 2'h0;
  localparam logic [2:0] RATE_RST = 3'h0;

  // conversion clock select
  localparam logic [1:0] CLKSEL_BUS = 2'h0;
  localparam logic [1:0] CLKSEL_HALF = 2'h1;
  localparam logic [1:0] CLKSEL_LOCAL = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int KHZ_PERIOD_NS = 1000000;
  localparam int KHZ_CYCLES = KHZ_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOCAL_PERIOD_NS = 200;
  localparam int LOCAL_CYCLES = LOCAL_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SAMPLE_TICKS = 4'h4;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [3:0] TOP_BIT = 4'h9;
  localparam logic [10:0] RATE_BASE = 11'h008;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;

endpackage : adc_ctrl_pkg

// ==== hdl/periodic_wakeup_counter.sv ====
// free-running periodic counter that issues the hardware trigger
`timescale 1ns/1ps
`default_nettype none
module periodic_wakeup_counter
  import adc_ctrl_pkg::*;
#(
  parameter int KHZ_DIV = KHZ_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic src_ref,
  input wire logic ref_edge,
  input wire logic [2:0] rate_sel,
  output logic overflow
);

  if (KHZ_DIV < 2 || KHZ_DIV > 65535) begin : g_chk
    $error("KHZ_DIV out of range");
  end

  logic [15:0] pre_q, pre_d;
  logic [10:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;
  logic tick;
  logic [10:0] limit;

  always_comb begin
    limit = (RATE_BASE << (rate_sel - 3'h1)) - 11'h001;
    pre_d = pre_q;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    tick = 1'b0;
    // internal slow tick is a divider of the bus clock
    if (run) begin
      if (pre_q == 16'(KHZ_DIV - 1)) begin
        pre_d = 16'h0000;
        tick = !src_ref; // RQ6
      end else begin
        pre_d = pre_q + 16'h0001;
      end
      if (src_ref) begin
        tick = ref_edge; // RQ6
      end
    end
    // rate zero stops the counter
    if (rate_sel == 3'h0) begin
      cnt_d = 11'h000;
    end else if (tick) begin
      if (cnt_q >= limit) begin
        cnt_d = 11'h000;
        ovf_d = 1'b1; // RQ5
      end else begin
        cnt_d = cnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 16'h0000;
      cnt_q <= 11'h000;
      ovf_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign overflow = ovf_q;

endmodule : periodic_wakeup_counter
`default_nettype wire

// ==== hdl/adc_channel_trigger_config.sv ====
// converter control: register slave, channel decode, sar sequencer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: decode selector to pins, ground, sensors, references
// RQ2: reserved codes give undefined results
// RQ3: software enables bandgap buffer before bandgap
// RQ4: conversion clock: bus, half bus, local
// RQ5: hardware trigger on each periodic overflow
// RQ6: periodic counter from reference or 1 kHz
// RQ7: periodic trigger runs in run, wait, stop3
// RQ8: stop3 needs both low-voltage enables set
// RQ9: keep converting in wait and stop3
// RQ10: ten-bit successive approximation, one bit per step
// RQ11: right-justified result, 10 or 8 bits
// RQ12: single and continuous; single returns idle
// RQ13: done flag with enabled interrupt
// RQ14: compare less-than or greater-equal, with interrupt
// RQ15: each pin gated by its enable bit
// RQ16: ground inputs convert to zero
// RQ17: control write aborts and restarts unless off; with hwt_q set the code aborts to idle and waits for the trigger
// RQ18: done clears on control write or result read
module adc_channel_trigger_config
  import adc_ctrl_pkg::*;
#(
  parameter int KHZ_DIV = KHZ_CYCLES,
  parameter int LOCAL_DIV = LOCAL_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic stop3_mode,
  input wire logic stop_other_mode,
  input wire logic lowvolt_detect_enable,
  input wire logic lowvolt_detect_stop_enable,
  input wire logic clock_module_ref_clock,
  input wire logic comparator_high,
  output logic [7:0] ext_pin_select,
  output logic [7:0] pin_analog_enable,
  output logic ground_select,
  output logic temp_sensor_select,
  output logic bandgap_select,
  output logic refh_select,
  output logic refl_select,
  output logic converter_on,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic hw_conversion_trigger,
  output logic irq
);

  if (LOCAL_DIV < 1 || LOCAL_DIV > 255) begin : g_chk
    $error("LOCAL_DIV out of range");
  end

  // pin synchronisers
  logic ref_s1_q, ref_s2_q, ref_prev_q, cmp_s1_q, cmp_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_prev_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= clock_module_ref_clock;
      ref_s2_q <= ref_s1_q;
      ref_prev_q <= ref_s2_q;
      cmp_s1_q <= comparator_high;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // register state
  logic ien_q, ien_d, cont_q, cont_d, done_q, done_d;
  logic [4:0] ch_q, ch_d;
  logic hwt_q, hwt_d, cmpen_q, cmpen_d, cmpge_q, cmpge_d;
  logic [9:0] cmpv_q, cmpv_d;
  logic mode8_q, mode8_d;
  logic [1:0] clksel_q, clksel_d;
  logic [7:0] apc_q, apc_d;
  logic psrc_q, psrc_d;
  logic [2:0] rate_q, rate_d;
  logic [1:0] ist_q, ist_d, imsk_q, imsk_d;

  // bus state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_fire, rd_fire, wr_sc1, rd_res, rd_ist, rd_ok;
  logic [31:0] rd_val;

  // conversion state
  conv_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d, samp_q, samp_d;
  logic [1:0] settle_q, settle_d;
  logic [9:0] code_q, code_d, result_q, result_d, dac_q, dac_d;
  logic [9:0] code_fin, res_new;
  logic [7:0] div_q, div_d;
  logic half_q, half_d;
  logic conv_tick, run_ok, finish, match, gnd_sel, per_ovf;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_SC1) || (a == OFF_SC2) || (a == OFF_RES) ||
             (a == OFF_CMPV) || (a == OFF_CFG) || (a == OFF_APC) ||
             (a == OFF_PER) || (a == OFF_IST) || (a == OFF_IMSK);
  endfunction : mapped

  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign arready = !rvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_fire = arvalid && arready;
  assign wr_sc1 = wr_fire && waddr_q == OFF_SC1 && wstrb_q[0];
  assign rd_res = rd_fire && araddr == OFF_RES;
  assign rd_ist = rd_fire && araddr == OFF_IST;

  always_comb begin
    rd_ok = 1'b1;
    if (araddr == OFF_SC1) begin
      rd_val = {24'h0, done_q, ien_q, cont_q, ch_q};
    end else if (araddr == OFF_SC2) begin
      rd_val = {24'h0, state_q != ST_IDLE, hwt_q, cmpen_q, cmpge_q, 4'h0};
    end else if (araddr == OFF_RES) begin
      rd_val = {22'h0, result_q};
    end else if (araddr == OFF_CMPV) begin
      rd_val = {22'h0, cmpv_q};
    end else if (araddr == OFF_CFG) begin
      rd_val = {29'h0, mode8_q, clksel_q};
    end else if (araddr == OFF_APC) begin
      rd_val = {24'h0, apc_q};
    end else if (araddr == OFF_PER) begin
      rd_val = {28'h0, psrc_q, rate_q};
    end else if (araddr == OFF_IST) begin
      rd_val = {30'h0, ist_q};
    end else if (araddr == OFF_IMSK) begin
      rd_val = {30'h0, imsk_q};
    end else begin
      rd_val = 32'h0;
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      waddr_d = {awaddr[7:2], 2'b00};
    end
    if (wvalid && wready) begin
      w_have_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d = rd_val;
      rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  // software registers, flags and sticky status
  always_comb begin
    ien_d = ien_q;
    cont_d = cont_q;
    ch_d = ch_q;
    hwt_d = hwt_q;
    cmpen_d = cmpen_q;
    cmpge_d = cmpge_q;
    cmpv_d = cmpv_q;
    mode8_d = mode8_q;
    clksel_d = clksel_q;
    apc_d = apc_q;
    psrc_d = psrc_q;
    rate_d = rate_q;
    imsk_d = imsk_q;
    if (wr_fire && wstrb_q[0]) begin
      if (waddr_q == OFF_SC1) begin
        ien_d = wdata_q[SC1_IEN_BIT];
        cont_d = wdata_q[SC1_CONT_BIT];
        ch_d = wdata_q[4:0];
      end else if (waddr_q == OFF_SC2) begin
        hwt_d = wdata_q[SC2_HWT_BIT];
        cmpen_d = wdata_q[SC2_CMPEN_BIT];
        cmpge_d = wdata_q[SC2_CMPGE_BIT];
      end else if (waddr_q == OFF_CMPV) begin
        cmpv_d[7:0] = wdata_q[7:0];
      end else if (waddr_q == OFF_CFG) begin
        mode8_d = wdata_q[CFG_MODE8_BIT];
        clksel_d = wdata_q[1:0];
      end else if (waddr_q == OFF_APC) begin
        apc_d = wdata_q[7:0]; // RQ15
      end else if (waddr_q == OFF_PER) begin
        psrc_d = wdata_q[PER_SRC_BIT];
        rate_d = wdata_q[2:0];
      end else if (waddr_q == OFF_IMSK) begin
        imsk_d = wdata_q[1:0];
      end
    end
    if (wr_fire && wstrb_q[1] && waddr_q == OFF_CMPV) begin
      cmpv_d[9:8] = wdata_q[9:8];
    end
    // a finishing conversion wins over a result-read clear in the same cycle; a control write cancels the finish
    done_d = (done_q && !wr_sc1 && !rd_res) || // RQ18
             (finish && (!cmpen_q || match)); // RQ13 RQ14
    ist_d = rd_ist ? 2'b00 : ist_q;
    if (finish) begin
      ist_d[IST_DONE_BIT] = 1'b1;
      ist_d[IST_CMP_BIT] = ist_d[IST_CMP_BIT] | (cmpen_q && match); // RQ14
    end
  end

  // conversion clock enable; the missing alternate source falls back
  // to the bus clock
  always_comb begin
    div_d = div_q;
    half_d = !half_q;
    conv_tick = 1'b1; // RQ4
    if (clksel_q == CLKSEL_HALF) begin
      conv_tick = half_q; // RQ4
    end else if (clksel_q == CLKSEL_LOCAL) begin
      conv_tick = div_q == 8'(LOCAL_DIV - 1); // RQ4
    end
    div_d = conv_tick && clksel_q == CLKSEL_LOCAL ? 8'h00 : div_q + 8'h01;
  end

  // wait keeps running; stop3 only with both supervisor enables
  assign run_ok = !stop_other_mode && (!stop3_mode ||
    (lowvolt_detect_enable && lowvolt_detect_stop_enable)); // RQ8 RQ9

  periodic_wakeup_counter #(
    .KHZ_DIV(KHZ_DIV)
  ) u_periodic (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!stop_other_mode), // RQ7
    .src_ref(psrc_q),
    .ref_edge(ref_s2_q && !ref_prev_q),
    .rate_sel(rate_q),
    .overflow(per_ovf)
  );

  assign gnd_sel = ch_q > CH_PIN_LAST && ch_q <= CH_GND_LAST;
  assign res_new = mode8_q ? {2'b00, code_fin[9:2]} : code_fin; // RQ11
  assign match = cmpge_q ? res_new >= cmpv_q : res_new < cmpv_q; // RQ14

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    samp_d = samp_q;
    settle_d = settle_q;
    code_d = code_q;
    result_d = result_q;
    code_fin = code_q;
    finish = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (per_ovf && hwt_q && ch_q != CH_OFF) begin
          state_d = ST_SAMPLE; // RQ5
          samp_d = 4'h0;
        end
      end
      ST_SAMPLE: begin
        if (conv_tick && run_ok) begin
          if (samp_q == SAMPLE_TICKS - 4'h1) begin
            state_d = ST_CONV;
            bit_d = TOP_BIT;
            code_d = 10'h000;
            settle_d = SETTLE_CYCLES;
          end else begin
            samp_d = samp_q + 4'h1;
          end
        end
      end
      ST_CONV: begin
        // comparator needs the dac to settle and the sync to catch up
        if (settle_q != 2'h0) begin
          settle_d = settle_q - 2'h1;
        end else if (conv_tick && run_ok) begin
          if (cmp_s2_q && !gnd_sel) begin // RQ16
            code_fin = code_q | (10'h001 << bit_q); // RQ10
          end
          code_d = code_fin;
          settle_d = SETTLE_CYCLES;
          if (bit_q == 4'h0) begin
            finish = 1'b1;
            result_d = res_new; // RQ11
            samp_d = 4'h0;
            state_d = cont_q ? ST_SAMPLE : ST_IDLE; // RQ12
          end else begin
            bit_d = bit_q - 4'h1; // RQ10
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (wr_sc1) begin
      finish = 1'b0;
      samp_d = 4'h0;
      state_d = wdata_q[4:0] != CH_OFF && !hwt_q ? ST_SAMPLE : ST_IDLE; // RQ17
    end
    dac_d = state_d == ST_CONV ? code_d | (10'h001 << bit_d) : 10'h000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
      ien_q <= 1'b0;
      cont_q <= 1'b0;
      done_q <= 1'b0;
      ch_q <= CH_RST;
      hwt_q <= 1'b0;
      cmpen_q <= 1'b0;
      cmpge_q <= 1'b0;
      cmpv_q <= 10'h000;
      mode8_q <= 1'b0;
      clksel_q <= CLKSEL_RST;
      apc_q <= 8'h00;
      psrc_q <= 1'b0;
      rate_q <= RATE_RST;
      ist_q <= 2'h0;
      imsk_q <= 2'h0;
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      samp_q <= 4'h0;
      settle_q <= 2'h0;
      code_q <= 10'h000;
      result_q <= 10'h000;
      dac_q <= 10'h000;
      div_q <= 8'h00;
      half_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ien_q <= ien_d;
      cont_q <= cont_d;
      done_q <= done_d;
      ch_q <= ch_d;
      hwt_q <= hwt_d;
      cmpen_q <= cmpen_d;
      cmpge_q <= cmpge_d;
      cmpv_q <= cmpv_d;
      mode8_q <= mode8_d;
      clksel_q <= clksel_d;
      apc_q <= apc_d;
      psrc_q <= psrc_d;
      rate_q <= rate_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      state_q <= state_d;
      bit_q <= bit_d;
      samp_q <= samp_d;
      settle_q <= settle_d;
      code_q <= code_d;
      result_q <= result_d;
      dac_q <= dac_d;
      div_q <= div_d;
      half_q <= half_d;
    end
  end

  // reserved codes select nothing, so their result is meaningless
  assign converter_on = state_q != ST_IDLE && ch_q != CH_OFF; // RQ1 RQ2
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign ext_pin_select[i] = converter_on && ch_q == 5'(i) &&
                               apc_q[i]; // RQ1 RQ15
  end
  assign ground_select = converter_on && (gnd_sel || ch_q == CH_REFL); // RQ1
  assign temp_sensor_select = converter_on && ch_q == CH_TEMP; // RQ1
  // bandgap is only valid if software powered its buffer first
  assign bandgap_select = converter_on && ch_q == CH_BGAP; // RQ1 RQ3
  assign refh_select = converter_on && ch_q == CH_REFH; // RQ1
  assign refl_select = converter_on && ch_q == CH_REFL; // RQ1
  assign pin_analog_enable = apc_q;
  assign sample_hold = state_q == ST_SAMPLE;
  assign dac_code = dac_q;
  assign hw_conversion_trigger = per_ovf;
  assign irq = (done_q && ien_q) || |(ist_q & imsk_q); // RQ13

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

endmodule : adc_channel_trigger_config
`default_nettype wire

// ==== tb/adc_ctrl_monitor.sv ====
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [7:0] ext_pin_select,
  input wire logic [7:0] pin_analog_enable,
  input wire logic ground_select,
  input wire logic temp_sensor_select,
  input wire logic bandgap_select,
  input wire logic refh_select,
  input wire logic converter_on,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic hw_conversion_trigger
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (awvalid && awready && wvalid && wready &&
    !bvalid |-> ##2 bvalid) else $error("write answer late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid &&
    $stable(rdata)) else $error("read answer unstable");
  pin_gate_a: assert property (|ext_pin_select |-> converter_on &&
    $onehot(ext_pin_select) && (ext_pin_select & ~pin_analog_enable) == 8'h00)
    else $error("pin select not gated");
  sel_excl_a: assert property ($onehot0({|ext_pin_select, ground_select,
    temp_sensor_select, bandgap_select, refh_select}))
    else $error("two inputs selected");
  trig_pulse_a: assert property (hw_conversion_trigger |=>
    !hw_conversion_trigger) else $error("trigger not a pulse");
  dac_idle_a: assert property (!converter_on |-> dac_code == 10'h000)
    else $error("trial code outside conversion");
  sample_len_a: assert property ($rose(sample_hold) |->
    sample_hold[*3] ##0 converter_on) else $error("sample phase short");
endmodule : adc_ctrl_monitor

bind adc_channel_trigger_config adc_ctrl_monitor u_adc_ctrl_monitor (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .rdata, .ext_pin_select,
  .pin_analog_enable, .ground_select, .temp_sensor_select, .bandgap_select,
  .refh_select, .converter_on, .sample_hold, .dac_code,
  .hw_conversion_trigger
);
`default_nettype wire

// ==== tb/adc_channel_trigger_config_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_channel_trigger_config_tb import adc_ctrl_pkg::*;;
  localparam int KDIV = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pen;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rd_q;
  logic [3:0] wstrb = 4'hF;
  logic stop3_mode = 1'b0, lowvolt_detect_enable = 1'b0;
  logic lowvolt_detect_stop_enable = 1'b0, clock_module_ref_clock = 1'b0;
  logic comparator_high, awready, wready, bvalid, arready, rvalid;
  logic ground_select, temp_sensor_select, bandgap_select, refh_select;
  logic refl_select, converter_on, sample_hold, hw_conversion_trigger, irq;
  logic [1:0] bresp, rresp, resp_q;
  logic [31:0] rdata;
  logic [7:0] ext_pin_select, pin_analog_enable;
  logic [9:0] dac_code, vin = 10'h000;
  int mismatches = 0, check_count = 0, seed = 30, rc = 0;

  always #25 aclk = ~aclk;
  // reference pin: rising edge every 6 bus cycles
  always @(posedge aclk) begin
    rc <= (rc + 1) % 6;
    clock_module_ref_clock <= (rc < 3);
  end
  // analog side: grounded inputs read as zero scale
  always_comb comparator_high = ground_select ? (dac_code == 10'h000)
                                              : (dac_code <= vin);

  adc_channel_trigger_config #(.KHZ_DIV(KDIV), .LOCAL_DIV(LOCAL_CYCLES))
    u_adc_channel_trigger_config (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .stop3_mode, .stop_other_mode(1'b0), .lowvolt_detect_enable,
    .lowvolt_detect_stop_enable, .clock_module_ref_clock, .comparator_high,
    .ext_pin_select, .pin_analog_enable, .ground_select, .temp_sensor_select,
    .bandgap_select, .refh_select, .refl_select, .converter_on, .sample_hold,
    .dac_code, .hw_conversion_trigger, .irq);

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    resp_q = bresp;
    bready <= 1'b0;
    if (n >= 50) mismatches++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
    if (n >= 50) mismatches++;
  endtask : rd

  function automatic logic [12:0] sel_exp(input logic [4:0] ch,
                                          input logic [7:0] p);
    logic [7:0] e;
    e = (ch <= CH_PIN_LAST) ? ((8'h01 << ch) & p) : 8'h00;
    sel_exp = {e, (ch > CH_PIN_LAST && ch <= CH_GND_LAST) || ch == CH_REFL,
               ch == CH_TEMP, ch == CH_BGAP, ch == CH_REFH, ch == CH_REFL};
  endfunction : sel_exp

  // one conversion from start to result read, with flags and interrupt
  task automatic conv(input logic [7:0] c1, input logic [2:0] cfg,
                      input logic [7:0] c2, input logic [9:0] cmp,
                      input logic [1:0] msk);
    int n;
    logic [4:0] ch;
    logic [9:0] res;
    logic hit;
    ch = c1[4:0];
    res = (ch > CH_PIN_LAST && ch <= CH_GND_LAST || ch == CH_REFL) ? 10'h000
          : vin;
    if (cfg[CFG_MODE8_BIT]) res = {2'b00, res[9:2]};
    hit = !c2[SC2_CMPEN_BIT] || (c2[SC2_CMPGE_BIT] ? res >= cmp : res < cmp);
    wr(OFF_CFG, {29'h0, cfg});
    wr(OFF_CMPV, {22'h0, cmp});
    wr(OFF_SC2, {24'h0, c2});
    wr(OFF_IMSK, {30'h0, msk});
    wr(OFF_SC1, {24'h0, c1});
    for (n = 0; n < 300 && sample_hold !== 1'b1; n++) @(posedge aclk);
    if (n >= 300) mismatches++;
    chk("selects", sel_exp(ch, pen), {ext_pin_select, ground_select,
        temp_sensor_select, bandgap_select, refh_select, refl_select});
    for (n = 0; n < 3000 && converter_on !== 1'b0; n++) @(posedge aclk);
    if (n >= 3000) mismatches++;
    repeat (2) @(posedge aclk);
    chk("idle", 1'b0, converter_on);
    chk("irq", (msk[0] | msk[1] & c2[SC2_CMPEN_BIT] & hit) | c1[6] & hit,
        irq);
    rd(OFF_SC1);
    chk("done", {hit, c1[6:0]}, rd_q[7:0]);
    rd(OFF_IST);
    chk("status", {c2[SC2_CMPEN_BIT] & hit, 1'b1}, rd_q[1:0]);
    rd(OFF_RES);
    chk("result", res, rd_q);
    rd(OFF_SC1);
    chk("done clear", 1'b0, rd_q[SC1_DONE_BIT]);
    chk("irq clear", 1'b0, irq);
  endtask : conv

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    end_sim();
  end

  initial begin
    logic [4:0] tbl [7];
    logic [4:0] ch;
    int i, n;
    tbl = '{5'h02, 5'h08, 5'h15, 5'h1A, 5'h1B, 5'h1D, 5'h1E};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_SC1);
    chk("sel reset", CH_RST, rd_q[4:0]);
    chk("irq reset", 1'b0, irq);
    rd(8'h24);
    chk("rd unmapped resp", RESP_SLVERR, resp_q);
    chk("rd unmapped data", 32'h0, rd_q);
    wr(8'h24, 32'hFFFF_FFFF);
    chk("wr unmapped", RESP_SLVERR, resp_q);
    pen = 8'($random(seed));
    pen[2] = 1'b1;
    wr(OFF_APC, {24'h0, pen});
    rd(OFF_APC);
    chk("pin enables", pen, rd_q);
    chk("pin enable out", pen, pin_analog_enable);
    $display("test registers done");
    for (i = 0; i < 11; i++) begin
      ch = (i < 7) ? tbl[i] : 5'($random(seed) & 7);
      vin = (i == 0) ? 10'h3FF : 10'($random(seed));
      stop3_mode <= (i == 4);
      lowvolt_detect_enable <= (i == 4);
      lowvolt_detect_stop_enable <= (i == 4);
      conv({1'b0, 1'($random(seed)), 1'b0, ch}, 3'($random(seed)),
           (i > 6) ? 8'h20 | (8'($random(seed)) & 8'h10) : 8'h00,
           10'($random(seed)), 2'($random(seed)));
    end
    $display("test conversions done");
    wr(OFF_SC2, 32'h0000_0000);
    wr(OFF_SC1, 32'h0000_0022);
    for (n = 0; n < 300 && sample_hold !== 1'b1; n++) @(posedge aclk);
    for (n = 0; n < 300 && sample_hold !== 1'b0; n++) @(posedge aclk);
    // a finished pass must fall straight back into sampling
    for (n = 0; n < 3000 && sample_hold !== 1'b1; n++) @(posedge aclk);
    chk("continuous", 1'b1, sample_hold);
    wr(OFF_SC1, {27'h0, CH_OFF});
    repeat (2) @(posedge aclk);
    chk("abort", 12'h000, {converter_on, sample_hold, dac_code});
    rd(OFF_SC1);
    chk("abort done", 1'b0, rd_q[SC1_DONE_BIT]);
    $display("test abort done");
    for (i = 0; i < 2; i++) begin
      wr(OFF_PER, {28'h0, i[0], 3'(i + 1)});
      for (n = 0; n < 500 && hw_conversion_trigger !== 1'b1; n++)
        @(posedge aclk);
      if (n >= 500) mismatches++;
      for (n = 1; n < 500; n++) begin
        @(posedge aclk);
        if (hw_conversion_trigger === 1'b1) break;
      end
      chk("trigger period", (i == 0) ? 8 * KDIV : 16 * 6, n);
    end
    vin = 10'($random(seed));
    stop3_mode <= 1'b1;
    lowvolt_detect_enable <= 1'b1;
    lowvolt_detect_stop_enable <= 1'b1;
    conv(8'h05, 3'h1, 8'h40, 10'h000, 2'h1);
    wr(OFF_PER, 32'h0000_0000);
    $display("test hardware trigger done");
    end_sim();
  end
endmodule : adc_channel_trigger_config_tb
`default_nettype wire
